// ---- pkg/ars_pkg.sv ----
// Package with constants, states and carrier types for the start-up sequencer.
package ars_pkg;

    // ***********************************************************
    // Timing
    // ***********************************************************
    localparam int unsigned ARS_CLK_MHZ = 125;
    localparam int unsigned ARS_PWRUP_MS = 1;
    localparam int unsigned ARS_RST_PULSE_US = 1;
    localparam int unsigned ARS_SEN_DELAY_NS = 100;
    localparam int unsigned ARS_SETTLE_MS = 50;
    localparam int unsigned ARS_PWRUP_CYC = ARS_PWRUP_MS * 1000 * ARS_CLK_MHZ;
    localparam int unsigned ARS_RST_PULSE_CYC = ARS_RST_PULSE_US * ARS_CLK_MHZ;
    localparam int unsigned ARS_SEN_DELAY_CYC = (ARS_SEN_DELAY_NS * ARS_CLK_MHZ + 999) / 1000;
    localparam int unsigned ARS_SETTLE_CYC = ARS_SETTLE_MS * 1000 * ARS_CLK_MHZ;
    localparam int unsigned ARS_CNT_W = 24;

    // ***********************************************************
    // Operating point of the sequence
    // ***********************************************************
    localparam logic [19:0] ARS_LINK_PARAM_CODE = 20'h82820;

    // ***********************************************************
    // Configuration groups and states
    // ***********************************************************
    localparam int unsigned ARS_GRP_W = 3;
    typedef enum logic [2:0] {
        ARS_GRP_ANALOG_TRIM,
        ARS_GRP_INTERLEAVE_A,
        ARS_GRP_INTERLEAVE_B,
        ARS_GRP_NONLIN_A,
        ARS_GRP_NONLIN_B,
        ARS_GRP_LINK_DDC
    } ars_grp_t;

    typedef enum {
        ARS_ST_IDLE,
        ARS_ST_PWR_WAIT,
        ARS_ST_RST_HIGH,
        ARS_ST_SEN_WAIT,
        ARS_ST_CFG_REQ,
        ARS_ST_CFG_BUSY,
        ARS_ST_SETTLE,
        ARS_ST_DONE
    } ars_state_t;

    // Request to the serial-port writer: which group to send.
    typedef struct packed {
        logic valid;
        ars_grp_t group;
    } ars_cfg_req_t;

endpackage : ars_pkg

// ---- design/ars_sequencer.sv ----
// Host-side start-up and hardware-reset sequencer for a dual-channel converter.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Sequence targets bypass, 12-bit, code 82820.
// - Reference clock enabled before reset pulse.
// - Reset is one low-high-low pulse.
// - Wait at least 1 ms before reset.
// - Hold reset high at least 1 us.
// - Wait 100 ns before first serial enable.
// - Analog trim set written first.
// - Interleave sets, channel A then B.
// - Wait 50 ms, no configuration meanwhile.
// - Nonlinearity sets, channel A then B.
// - Finally link and downconverter setup.
module ars_sequencer
    import ars_pkg::*;
#(
    parameter int unsigned PWRUP_CYC = ARS_PWRUP_CYC,
    parameter int unsigned SETTLE_CYC = ARS_SETTLE_CYC
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic cfg_done,
    output ars_cfg_req_t cfg_req,
    output logic sysref_en,
    output logic dev_reset,
    output logic serial_port_select_gate,
    output logic busy,
    output logic done,
    output logic [19:0] link_param_code
);

    // ***********************************************************
    // State and counters
    // ***********************************************************
    ars_state_t state_r, state_nxt;
    logic [ARS_CNT_W-1:0] cnt_r, cnt_nxt;
    ars_grp_t grp_r, grp_nxt;
    ars_cfg_req_t req_r, req_nxt;
    logic sysref_r, sysref_nxt;
    logic rst_pin_r, rst_pin_nxt;
    logic sen_ok_r, sen_ok_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic cfg_done_s1_r, cfg_done_s2_r;

    wire logic [ARS_CNT_W-1:0] pwr_lim = ARS_CNT_W'(PWRUP_CYC - 1);
    wire logic [ARS_CNT_W-1:0] rst_lim = ARS_CNT_W'(ARS_RST_PULSE_CYC - 1);
    wire logic [ARS_CNT_W-1:0] sen_lim = ARS_CNT_W'(ARS_SEN_DELAY_CYC - 1);
    wire logic [ARS_CNT_W-1:0] set_lim = ARS_CNT_W'(SETTLE_CYC - 1);
    wire logic [ARS_CNT_W-1:0] cnt_inc = cnt_r + ARS_CNT_W'(1);
    wire logic last_grp = (grp_r == ARS_GRP_LINK_DDC);
    wire logic settle_after = (grp_r == ARS_GRP_INTERLEAVE_B);
    wire ars_grp_t grp_inc = ars_grp_t'(grp_r + ARS_GRP_W'(1));

    // ***********************************************************
    // Sequencing
    // ***********************************************************
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        grp_nxt = grp_r;
        req_nxt = req_r;
        sysref_nxt = sysref_r;
        rst_pin_nxt = rst_pin_r;
        sen_ok_nxt = sen_ok_r;
        busy_nxt = busy_r;
        done_nxt = done_r;
        unique case (state_r)
            ARS_ST_IDLE:
            begin
                if (start)
                begin
                    // The reference is started with the power-on wait, ahead of reset.
                    sysref_nxt = 1'b1;
                    busy_nxt = 1'b1;
                    done_nxt = 1'b0;
                    cnt_nxt = '0;
                    state_nxt = ARS_ST_PWR_WAIT;
                end
            end
            ARS_ST_PWR_WAIT:
            begin
                cnt_nxt = cnt_inc;
                if (cnt_r >= pwr_lim)
                begin
                    cnt_nxt = '0;
                    rst_pin_nxt = 1'b1;
                    state_nxt = ARS_ST_RST_HIGH;
                end
            end
            ARS_ST_RST_HIGH:
            begin
                cnt_nxt = cnt_inc;
                if (cnt_r >= rst_lim)
                begin
                    cnt_nxt = '0;
                    rst_pin_nxt = 1'b0;
                    state_nxt = ARS_ST_SEN_WAIT;
                end
            end
            ARS_ST_SEN_WAIT:
            begin
                cnt_nxt = cnt_inc;
                if (cnt_r >= sen_lim)
                begin
                    sen_ok_nxt = 1'b1;
                    grp_nxt = ARS_GRP_ANALOG_TRIM;
                    state_nxt = ARS_ST_CFG_REQ;
                end
            end
            ARS_ST_CFG_REQ:
            begin
                req_nxt.valid = 1'b1;
                req_nxt.group = grp_r;
                state_nxt = ARS_ST_CFG_BUSY;
            end
            ARS_ST_CFG_BUSY:
            begin
                req_nxt.valid = 1'b0;
                if (cfg_done_s2_r)
                begin
                    cnt_nxt = '0;
                    if (last_grp)
                    begin
                        busy_nxt = 1'b0;
                        done_nxt = 1'b1;
                        state_nxt = ARS_ST_DONE;
                    end
                    else if (settle_after)
                    begin
                        sen_ok_nxt = 1'b0;
                        state_nxt = ARS_ST_SETTLE;
                    end
                    else
                    begin
                        // Groups run in enum order: A before B.
                        grp_nxt = grp_inc;
                        state_nxt = ARS_ST_CFG_REQ;
                    end
                end
            end
            ARS_ST_SETTLE:
            begin
                cnt_nxt = cnt_inc;
                if (cnt_r >= set_lim)
                begin
                    sen_ok_nxt = 1'b1;
                    grp_nxt = ARS_GRP_NONLIN_A;
                    state_nxt = ARS_ST_CFG_REQ;
                end
            end
            ARS_ST_DONE:
            begin
                if (start)
                begin
                    done_nxt = 1'b0;
                    busy_nxt = 1'b1;
                    // The gate must fall again, or the next reset pulse runs with the port open.
                    sen_ok_nxt = 1'b0;
                    cnt_nxt = '0;
                    state_nxt = ARS_ST_PWR_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= ARS_ST_IDLE;
            cnt_r <= '0;
            grp_r <= ARS_GRP_ANALOG_TRIM;
            req_r <= '0;
            sysref_r <= 1'b0;
            rst_pin_r <= 1'b0;
            sen_ok_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            grp_r <= grp_nxt;
            req_r <= req_nxt;
            sysref_r <= sysref_nxt;
            rst_pin_r <= rst_pin_nxt;
            sen_ok_r <= sen_ok_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    // The writer may run on another clock, so its completion is synchronised.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_done_s1_r <= 1'b0;
            cfg_done_s2_r <= 1'b0;
        end
        else
        begin
            cfg_done_s1_r <= cfg_done;
            cfg_done_s2_r <= cfg_done_s1_r;
        end
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    assign cfg_req = req_r;
    assign sysref_en = sysref_r;
    assign dev_reset = rst_pin_r;
    assign serial_port_select_gate = sen_ok_r;
    assign busy = busy_r;
    assign done = done_r;
    assign link_param_code = ARS_LINK_PARAM_CODE;

endmodule : ars_sequencer

`default_nettype wire

// ---- testbench/ars_seq_checker.sv ----
// Port checker for the start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module ars_seq_checker
    import ars_pkg::*;
#(
    parameter int unsigned PWRUP_CYC = 20,
    parameter int unsigned SETTLE_CYC = 50
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ars_cfg_req_t cfg_req,
    input wire logic sysref_en,
    input wire logic dev_reset,
    input wire logic serial_port_select_gate,
    input wire logic busy,
    input wire logic done,
    input wire logic [19:0] link_param_code
);
    // ********
    // Cycle counters
    // ********
    logic [31:0] hi_r;
    logic [31:0] lo_r;
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hi_r <= 32'h0;
            lo_r <= 32'h0;
        end
        else
        begin
            hi_r <= dev_reset ? hi_r + 32'h1 : 32'h0;
            lo_r <= serial_port_select_gate ? 32'h0 : lo_r + 32'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence rst_drop_s;
        $fell(dev_reset);
    endsequence
    sequence gate_wait_s;
        !serial_port_select_gate [*8] ##1 !serial_port_select_gate [*5];
    endsequence
    pwr_wait_a: assert property ($rose(dev_reset) |-> $past(busy, PWRUP_CYC)
        && !$past(busy, PWRUP_CYC + 1)) else $error("reset pulse timing off");
    rst_width_a: assert property (rst_drop_s |-> hi_r >= 32'd125)
        else $error("reset pulse too short");
    sen_delay_a: assert property (rst_drop_s |-> gate_wait_s ##1 serial_port_select_gate)
        else $error("serial gate delay wrong");
    req_gated_a: assert property (cfg_req.valid |-> serial_port_select_gate && !dev_reset)
        else $error("request outside gate");
    single_req_a: assert property (cfg_req.valid |=> !cfg_req.valid)
        else $error("request longer than one cycle");
    grp_order_a: assert property (cfg_req.valid && cfg_req.group != ARS_GRP_ANALOG_TRIM
        |-> cfg_req.group == $past(cfg_req.group) + 3'h1) else $error("group order wrong");
    settle_a: assert property ($rose(serial_port_select_gate)
        && cfg_req.group == ARS_GRP_INTERLEAVE_B |-> lo_r >= SETTLE_CYC)
        else $error("settle wait too short");
    done_last_a: assert property ($rose(done) |-> cfg_req.group == ARS_GRP_LINK_DDC && !busy)
        else $error("done before last group");
    code_a: assert property (link_param_code == 20'h82820)
        else $error("link code wrong");
    gate_in_reset_a: assert property (dev_reset |-> !serial_port_select_gate)
        else $error("serial gate open during reset");
    sysref_first_a: assert property ($rose(dev_reset) |-> sysref_en)
        else $error("reset pulse without reference");
endmodule : ars_seq_checker
bind ars_sequencer ars_seq_checker #(.PWRUP_CYC(PWRUP_CYC), .SETTLE_CYC(SETTLE_CYC)) i_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .sysref_en(sysref_en),
    .dev_reset(dev_reset),
    .serial_port_select_gate(serial_port_select_gate), .busy(busy), .done(done),
    .link_param_code(link_param_code));
`default_nettype wire

// ---- testbench/ars_dev_model.sv ----
// Model of the converter and its serial writer answering group requests.
`timescale 1ns/1ps
`default_nettype none
module ars_dev_model
    import ars_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ars_cfg_req_t cfg_req,
    input wire logic sysref_en,
    input wire logic dev_reset,
    input wire logic serial_port_select_gate,
    input wire logic slow,
    output logic cfg_done,
    output logic [7:0] err_cnt
);
    logic [2:0] exp_r;
    initial
    begin
        cfg_done = 1'b0;
        err_cnt = 8'h0;
        exp_r = 3'h0;
    end
    // Every reset pulse wipes the trim, so the order restarts.
    always @(posedge dev_reset)
    begin
        exp_r = 3'h0;
        if (sysref_en !== 1'b1) err_cnt = err_cnt + 8'h1;
    end
    always @(posedge sys_clk)
    begin
        if (sys_rst === 1'b0 && cfg_req.valid === 1'b1)
        begin
            if (cfg_req.group !== exp_r || serial_port_select_gate !== 1'b1)
                err_cnt = err_cnt + 8'h1;
            exp_r = exp_r + 3'h1;
            repeat (slow ? 9 : 1) @(negedge sys_clk);
            cfg_done = 1'b1;
            repeat (2) @(negedge sys_clk);
            cfg_done = 1'b0;
        end
    end
endmodule : ars_dev_model
`default_nettype wire

// ---- testbench/test_adc_startup_reset_sequencer.sv ----
// Testbench of the start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_adc_startup_reset_sequencer;
    import ars_pkg::*;
    logic sys_clk, sys_rst, start, cfg_done, slow, sysref_en, dev_reset, gate, busy, done;
    ars_cfg_req_t cfg_req;
    logic [19:0] code;
    logic [7:0] dev_err;
    int bad_count = 0;
    int num_checks = 0;
    ars_sequencer #(.PWRUP_CYC(20), .SETTLE_CYC(50)) i_dut (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .start(start), .cfg_done(cfg_done), .cfg_req(cfg_req),
        .sysref_en(sysref_en), .dev_reset(dev_reset), .serial_port_select_gate(gate),
        .busy(busy), .done(done), .link_param_code(code));
    ars_dev_model i_dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_req(cfg_req),
        .sysref_en(sysref_en), .dev_reset(dev_reset), .serial_port_select_gate(gate),
        .slow(slow), .cfg_done(cfg_done), .err_cnt(dev_err));
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // Watched outputs are picked by index, so the wait task needs no reference argument.
    wire logic [4:0] watch = {cfg_req.valid, done, gate, dev_reset, busy};
    localparam int W_BUSY = 0;
    localparam int W_RST = 1;
    localparam int W_GATE = 2;
    localparam int W_DONE = 3;
    localparam int W_VALID = 4;
    task automatic wait_for(input int sel, input logic lvl, output int n);
        n = 0;
        while (watch[sel] !== lvl && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_for
    // A start pulse while busy must not restart the sequence.
    task automatic run_seq(input logic slow_in, input logic poke);
        int n;
        @(negedge sys_clk);
        slow = slow_in;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        wait_for(W_BUSY, 1'b1, n);
        check(n < 2, 1'b1);
        start = poke;
        wait_for(W_RST, 1'b1, n);
        start = 1'b0;
        check(n, 20);
        wait_for(W_RST, 1'b0, n);
        check(n, ARS_RST_PULSE_CYC);
        wait_for(W_GATE, 1'b1, n);
        check(n, ARS_SEN_DELAY_CYC);
        wait_for(W_DONE, 1'b1, n);
        check(n < 3000, 1'b1);
        check({busy, cfg_req.group}, {1'b0, ARS_GRP_LINK_DDC});
        check({dev_err, code}, {8'h0, 20'h82820});
    endtask : run_seq
    task automatic mid_reset;
        int n;
        @(negedge sys_clk);
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        wait_for(W_VALID, 1'b1, n);
        sys_rst = 1'b1;
        @(negedge sys_clk);
        check({sysref_en, dev_reset, gate, busy, done, cfg_req.valid}, 6'h0);
        sys_rst = 1'b0;
    endtask : mid_reset
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        sys_rst = 1'b1;
        start = 1'b0;
        slow = 1'b0;
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        run_seq(1'b0, 1'b0);
        run_seq(1'b1, 1'b1);
        mid_reset();
        run_seq(1'b0, 1'b0);
        report_and_stop();
    end
endmodule : test_adc_startup_reset_sequencer
`default_nettype wire
